/* logic/uart_modem_consts.svh */
// Offsets, bit positions, reset values and widths for the modem status and flow threshold block
`ifndef UART_MODEM_CONSTS_SVH
`define UART_MODEM_CONSTS_SVH

// Register offsets, all sharing one slot and told apart by bank controls
`define UMS_ADDR_W 4
`define UMS_OFS_MODEM_STATE 4'h6
`define UMS_OFS_LEVELS 4'h6
`define UMS_OFS_PAUSE 4'h6

// Bank selection
`define UMS_ENH_KEY 8'hBF
`define UMS_FMT_DIV_BIT 7
`define UMS_FEAT_BANK_BIT 2
`define UMS_ENH_LEVELS_BIT 4

// Modem output control bits
`define UMS_CTRL_LOOP_BIT 4
`define UMS_CTRL_OUT2_BIT 3
`define UMS_CTRL_OUT1_BIT 2
`define UMS_CTRL_RTS_BIT 1
`define UMS_CTRL_DTR_BIT 0

// Positions inside the four-bit modem vector {cd, ri, dsr, cts}
`define UMS_IDX_CD 3
`define UMS_IDX_RI 2
`define UMS_IDX_DSR 1
`define UMS_IDX_CTS 0

// Threshold nibbles and step
`define UMS_HALT_MSB 3
`define UMS_HALT_LSB 0
`define UMS_RESUME_MSB 7
`define UMS_RESUME_LSB 4
`define UMS_STEP_SHIFT 2
`define UMS_CNT_W 7

// Reset values
`define UMS_PAUSE_RST 8'h00
`define UMS_LEVELS_RST 8'h00
`define UMS_DELTA_RST 4'h0
`define UMS_STATE_RST 4'h0
`define UMS_PIN_IDLE 1'b1
`define UMS_RDATA_RST 8'h00

`endif

/* logic/uart_modem_pkg.sv */
// Types shared by the modem status and flow threshold block
`include "uart_modem_consts.svh"

package uart_modem_pkg;

  // Active-low modem input pins
  typedef struct packed {
    logic carrierDetectN;
    logic ringIndicatorN;
    logic dataSetReadyN;
    logic clearToSendN;
  } modem_pins_s;

  // Host register port request
  typedef struct packed {
    logic [`UMS_ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {SEL_NONE, SEL_STATE, SEL_LEVELS, SEL_PAUSE} reg_sel_e;

  typedef enum logic {FLOW_RUN, FLOW_HALT} flow_state_e;

endpackage : uart_modem_pkg

/* logic/modem_input_sync.sv */
// Two-stage synchroniser for the four modem input pins
`timescale 1ns/1ps
`include "uart_modem_consts.svh"

module modem_input_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] pinsN,
  output logic [3:0] syncN
);

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : gSync
      logic stage1_r;
      logic stage2_r;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stage1_r <= `UMS_PIN_IDLE;
          stage2_r <= `UMS_PIN_IDLE;
        end else begin
          stage1_r <= pinsN[i];
          stage2_r <= stage1_r;
        end
      end
      assign syncN[i] = stage2_r;
    end
  endgenerate

endmodule : modem_input_sync

/* logic/flow_threshold_ctrl.sv */
// Receive FIFO halt and resume threshold tracking
`timescale 1ns/1ps
`include "uart_modem_consts.svh"

module flow_threshold_ctrl
  import uart_modem_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic swReset,
  input wire logic [7:0] levels,
  input wire logic [`UMS_CNT_W-1:0] rxFifoCount,
  input wire logic autoSwFlowEn,
  output logic halted,
  output logic pauseSend,
  output logic resumeSend
);

  flow_state_e state_r;
  flow_state_e state_nxt;
  logic [`UMS_CNT_W-1:0] haltMark;
  logic [`UMS_CNT_W-1:0] resumeMark;
  logic haltHit;
  logic resumeHit;
  logic pauseSend_r;
  logic resumeSend_r;

  // **********************************************
  // Levels in steps of four bytes
  // **********************************************
  assign haltMark = `UMS_CNT_W'(levels[`UMS_HALT_MSB:`UMS_HALT_LSB]) << `UMS_STEP_SHIFT;
  assign resumeMark = `UMS_CNT_W'(levels[`UMS_RESUME_MSB:`UMS_RESUME_LSB]) << `UMS_STEP_SHIFT;
  // Zero halt nibble leaves flow running
  assign haltHit = (haltMark != '0) && (rxFifoCount >= haltMark);
  assign resumeHit = rxFifoCount <= resumeMark;

  // **********************************************
  // Flow state
  // **********************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FLOW_RUN: begin
        if (haltHit) begin
          state_nxt = FLOW_HALT;
        end
      end
      FLOW_HALT: begin
        if (resumeHit) begin
          state_nxt = FLOW_RUN;
        end
      end
      default: begin
        state_nxt = FLOW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= FLOW_RUN;
    end else if (swReset) begin
      state_r <= FLOW_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pause and resume character requests, one pulse per crossing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pauseSend_r <= 1'b0;
      resumeSend_r <= 1'b0;
    end else begin
      pauseSend_r <= !swReset && autoSwFlowEn && state_r == FLOW_RUN && state_nxt == FLOW_HALT;
      resumeSend_r <= !swReset && autoSwFlowEn && state_r == FLOW_HALT && state_nxt == FLOW_RUN;
    end
  end

  assign halted = state_r == FLOW_HALT;
  assign pauseSend = pauseSend_r;
  assign resumeSend = resumeSend_r;

  // **********************************************
  // Checks
  // **********************************************
  flow_resume_a: assert property (@(posedge clk) disable iff (rst)
    (halted && rxFifoCount <= resumeMark && !swReset && autoSwFlowEn) |=> (!halted && resumeSend))
    else $error("flow did not resume at resume level");

  flow_halt_a: assert property (@(posedge clk) disable iff (rst)
    (!halted && haltMark != '0 && rxFifoCount >= haltMark && !swReset) |=> halted)
    else $error("flow did not halt at halt level");

  pause_once_a: assert property (@(posedge clk) disable iff (rst)
    pauseSend |-> ($past(autoSwFlowEn) && halted && !$past(halted)))
    else $error("pause request without a halt crossing");

endmodule : flow_threshold_ctrl

/* logic/uart_modem_status_flow_thresholds.sv */
// Modem input status, change flags and receive flow thresholds for one channel
`timescale 1ns/1ps
`include "uart_modem_consts.svh"

// ********************************************************************
// Functional notes
// - Status bit 7 is the inverted carrier detect pin, or control bit 3 in loopback.
// - Status bit 6 is the inverted ring indicator pin, or control bit 2 in loopback.
// - Status bit 5 is the inverted data set ready pin, or control bit 0 in loopback.
// - Status bit 4 is the inverted clear to send pin, or control bit 1 in loopback.
// - Status bit 3 sets on any change of carrier detect.
// - Status bit 2 sets only when the ring indicator pin rises from low to high.
// - Status bit 1 sets on any change of data set ready.
// - Status bit 0 sets on any change of clear to send.
// - Any set change flag with the modem interrupt enabled raises the modem interrupt.
// - At or below four times the upper nibble the sender is resumed by RTS or a resume character.
// - At or above four times a non-zero lower nibble the sender is halted by RTS or a pause character.
// - The pause character sits at offset 6 when the format control is 0xBF and feature bit 2 is clear.
// - The pause character is cleared by power-on reset only, never by software reset.
// ********************************************************************

module uart_modem_status_flow_thresholds
  import uart_modem_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic swReset,
  input wire reg_req_s regReq,
  output logic [7:0] rdData,
  output logic rdValid,
  input wire modem_pins_s modemPins,
  input wire logic [7:0] modemOutputControl,
  input wire logic [7:0] lineFormatControl,
  input wire logic [7:0] specialFeatureControl,
  input wire logic [7:0] enhancedFeatures,
  input wire logic modemIntEn,
  input wire logic autoRtsEn,
  input wire logic autoSwFlowEn,
  input wire logic [`UMS_CNT_W-1:0] rxFifoCount,
  output logic requestToSendN,
  output logic pauseSend,
  output logic resumeSend,
  output logic [7:0] pauseChar,
  output logic modemIrq
);

  logic [3:0] pinSyncN;
  logic [3:0] liveState;
  logic [3:0] loopState;
  logic [3:0] prevState_r;
  logic [3:0] changed;
  logic [3:0] setMask;
  logic [3:0] deltas_r;
  logic [3:0] deltas_nxt;
  logic [7:0] pauseChar_r;
  logic [7:0] levels_r;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic rdValid_r;
  logic rts_r;
  logic loopback;
  logic halted;
  logic stateRead;
  logic [7:0] modemInputState;
  reg_sel_e regSel;

  // ********************************************************************
  // Register bank decode
  // ********************************************************************
  function automatic reg_sel_e decodeSel(
    input logic [`UMS_ADDR_W-1:0] addr,
    input logic [7:0] fmt,
    input logic [7:0] ctrl,
    input logic [7:0] feat,
    input logic [7:0] enh
  );
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr == `UMS_OFS_PAUSE && fmt == `UMS_ENH_KEY && !feat[`UMS_FEAT_BANK_BIT]) begin
      sel = SEL_PAUSE;
    end else if (addr == `UMS_OFS_LEVELS && enh[`UMS_ENH_LEVELS_BIT] && ctrl[`UMS_CTRL_OUT1_BIT]) begin
      sel = SEL_LEVELS;
    end else if (addr == `UMS_OFS_MODEM_STATE && !fmt[`UMS_FMT_DIV_BIT] && !ctrl[`UMS_CTRL_OUT1_BIT]) begin
      sel = SEL_STATE;
    end
    return sel;
  endfunction : decodeSel

  assign regSel = decodeSel(regReq.addr, lineFormatControl, modemOutputControl,
                            specialFeatureControl, enhancedFeatures);
  assign stateRead = regReq.rd && regSel == SEL_STATE;

  // ********************************************************************
  // Modem inputs
  // ********************************************************************
  modem_input_sync uSync (
    .clk(clk),
    .rst(rst),
    .pinsN(modemPins),
    .syncN(pinSyncN)
  );

  assign loopback = modemOutputControl[`UMS_CTRL_LOOP_BIT];

  // Loopback order {cd, ri, dsr, cts}
  assign loopState = {modemOutputControl[`UMS_CTRL_OUT2_BIT], modemOutputControl[`UMS_CTRL_OUT1_BIT],
                      modemOutputControl[`UMS_CTRL_DTR_BIT], modemOutputControl[`UMS_CTRL_RTS_BIT]};

  // Pins are active low, status bits active high
  assign liveState = loopback ? loopState : ~pinSyncN;

  // ********************************************************************
  // Change flags
  // ********************************************************************
  assign changed = liveState ^ prevState_r;

  // Ring flag only on the pin rising, which is the status bit falling
  assign setMask = {changed[`UMS_IDX_CD],
                    prevState_r[`UMS_IDX_RI] & ~liveState[`UMS_IDX_RI],
                    changed[`UMS_IDX_DSR],
                    changed[`UMS_IDX_CTS]};

  // New change wins over the read that clears
  assign deltas_nxt = (stateRead ? `UMS_DELTA_RST : deltas_r) | setMask;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevState_r <= `UMS_STATE_RST;
    end else begin
      prevState_r <= liveState;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deltas_r <= `UMS_DELTA_RST;
    end else if (swReset) begin
      deltas_r <= `UMS_DELTA_RST;
    end else begin
      deltas_r <= deltas_nxt;
    end
  end

  assign modemInputState = {liveState, deltas_r};

  assign modemIrq = modemIntEn && (deltas_r != `UMS_DELTA_RST);

  // ********************************************************************
  // Writable registers
  // ********************************************************************
  // Power-on reset only; software reset leaves it alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pauseChar_r <= `UMS_PAUSE_RST;
    end else if (regReq.wr && regSel == SEL_PAUSE) begin
      pauseChar_r <= regReq.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      levels_r <= `UMS_LEVELS_RST;
    end else if (swReset) begin
      levels_r <= `UMS_LEVELS_RST;
    end else if (regReq.wr && regSel == SEL_LEVELS) begin
      levels_r <= regReq.wdata;
    end
  end

  assign pauseChar = pauseChar_r;

  // ********************************************************************
  // Read port
  // ********************************************************************
  always_comb begin
    rdData_nxt = `UMS_RDATA_RST;
    case (regSel)
      SEL_STATE: begin
        rdData_nxt = modemInputState;
      end
      SEL_LEVELS: begin
        rdData_nxt = levels_r;
      end
      SEL_PAUSE: begin
        rdData_nxt = pauseChar_r;
      end
      default: begin
        rdData_nxt = `UMS_RDATA_RST;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_r <= `UMS_RDATA_RST;
    end else if (regReq.rd) begin
      rdData_r <= rdData_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= regReq.rd;
    end
  end

  assign rdData = rdData_r;
  assign rdValid = rdValid_r;

  // ********************************************************************
  // Receive flow thresholds
  // ********************************************************************
  flow_threshold_ctrl uFlow (
    .clk(clk),
    .rst(rst),
    .swReset(swReset),
    .levels(levels_r),
    .rxFifoCount(rxFifoCount),
    .autoSwFlowEn(autoSwFlowEn),
    .halted(halted),
    .pauseSend(pauseSend),
    .resumeSend(resumeSend)
  );

  // Pin high means not ready; loopback keeps the pin idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rts_r <= 1'b1;
    end else if (loopback) begin
      rts_r <= 1'b1;
    end else if (autoRtsEn) begin
      rts_r <= halted;
    end else begin
      rts_r <= !modemOutputControl[`UMS_CTRL_RTS_BIT];
    end
  end

  assign requestToSendN = rts_r;

  // ********************************************************************
  // Checks
  // ********************************************************************
  cd_loop_read_a: assert property (@(posedge clk) disable iff (rst)
    (stateRead && loopback) |=> (rdValid && rdData[7] == $past(modemOutputControl[`UMS_CTRL_OUT2_BIT])))
    else $error("carrier status not following loopback control");

  ri_pin_a: assert property (@(posedge clk) disable iff (rst)
    !loopback |-> (liveState[`UMS_IDX_RI] == !$past(modemPins.ringIndicatorN, 2)))
    else $error("ring status not inverse of pin");

  dsr_pin_a: assert property (@(posedge clk) disable iff (rst)
    (stateRead && !loopback) |=> (rdData[5] == !$past(modemPins.dataSetReadyN, 3)))
    else $error("data set ready status not inverse of pin");

  cts_loop_a: assert property (@(posedge clk) disable iff (rst)
    loopback |-> (liveState[`UMS_IDX_CTS] == modemOutputControl[`UMS_CTRL_RTS_BIT]))
    else $error("clear to send status not following loopback control");

  cd_delta_a: assert property (@(posedge clk) disable iff (rst || swReset)
    (liveState[`UMS_IDX_CD] != prevState_r[`UMS_IDX_CD]) |=> deltas_r[`UMS_IDX_CD])
    else $error("carrier change not flagged");

  ri_rise_a: assert property (@(posedge clk) disable iff (rst || swReset)
    $rose(deltas_r[`UMS_IDX_RI]) |-> $past(prevState_r[`UMS_IDX_RI] && !liveState[`UMS_IDX_RI]))
    else $error("ring flag set without pin rising");

  dsr_delta_a: assert property (@(posedge clk) disable iff (rst || swReset)
    (liveState[`UMS_IDX_DSR] != prevState_r[`UMS_IDX_DSR]) |=> deltas_r[`UMS_IDX_DSR])
    else $error("data set ready change not flagged");

  cts_delta_a: assert property (@(posedge clk) disable iff (rst || swReset)
    (liveState[`UMS_IDX_CTS] != prevState_r[`UMS_IDX_CTS]) |=> deltas_r[`UMS_IDX_CTS])
    else $error("clear to send change not flagged");

  modem_irq_a: assert property (@(posedge clk) disable iff (rst)
    (modemIntEn && $past(setMask != 4'h0) && !$past(swReset)) |-> modemIrq)
    else $error("modem interrupt missing after change");

  rts_flow_a: assert property (@(posedge clk) disable iff (rst)
    ($past(autoRtsEn) && !$past(loopback) && $past(halted)) |-> requestToSendN)
    else $error("request to send not dropped while halted");

  pause_write_a: assert property (@(posedge clk) disable iff (rst)
    (regReq.wr && regSel == SEL_PAUSE) |=> (pauseChar == $past(regReq.wdata)))
    else $error("pause character write lost");

  pause_keep_a: assert property (@(posedge clk) disable iff (rst)
    (swReset && !regReq.wr) |=> $stable(pauseChar))
    else $error("software reset disturbed pause character");

  read_clear_a: assert property (@(posedge clk) disable iff (rst)
    (stateRead && setMask == 4'h0) |=> (deltas_r == 4'h0))
    else $error("change flags not cleared by status read");

endmodule : uart_modem_status_flow_thresholds

/* bench/remote_modem_model.sv */
// Remote modem that drives the four active-low status lines toward the bench's request
`timescale 1ns/1ps

module remote_modem_model
  import uart_modem_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] wantActive,
  input wire logic [1:0] lag,
  output modem_pins_s pins
);
  // ********************************************************************
  // Line drivers
  // ********************************************************************
  initial begin
    pins = modem_pins_s'(4'hF);
  end

  // Lines follow the request after a chosen lag, off the clock edge
  always begin
    @(posedge clk);
    if (pins !== modem_pins_s'(~wantActive)) begin
      repeat (lag) @(posedge clk);
      #1 pins = modem_pins_s'(~wantActive);
    end
  end
endmodule : remote_modem_model

/* bench/uart_modem_status_flow_thresholds_tb_top.sv */
// Self-checking bench for the modem status and flow threshold block
`timescale 1ns/1ps
`include "uart_modem_consts.svh"

module uart_modem_status_flow_thresholds_tb_top
  import uart_modem_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic swReset = 1'b0;
  reg_req_s regReq = '0;
  logic [7:0] rdData;
  logic rdValid;
  modem_pins_s modemPins;
  logic [7:0] modemOutputControl = 8'h00;
  logic [7:0] lineFormatControl = 8'h03;
  logic [7:0] specialFeatureControl = 8'h00;
  logic [7:0] enhancedFeatures = 8'h00;
  logic modemIntEn = 1'b0;
  logic autoRtsEn = 1'b0;
  logic autoSwFlowEn = 1'b0;
  logic [`UMS_CNT_W-1:0] rxFifoCount = '0;
  logic requestToSendN, pauseSend, resumeSend, modemIrq;
  logic [7:0] pauseChar;
  logic [3:0] wantActive = 4'h0;
  logic [1:0] lag = 2'd0;
  integer seed = 32'h02B35586;
  int badCount = 0;
  int checksDone = 0;
  logic [7:0] mLev = 8'h00;
  logic mHalt, mPause, mResume, mRtsN;
  logic flowChk = 1'b0;

  always #5 clk = ~clk;

  uart_modem_status_flow_thresholds i_dut (.clk, .rst, .swReset, .regReq, .rdData, .rdValid, .modemPins,
    .modemOutputControl, .lineFormatControl, .specialFeatureControl, .enhancedFeatures, .modemIntEn,
    .autoRtsEn, .autoSwFlowEn, .rxFifoCount, .requestToSendN, .pauseSend, .resumeSend, .pauseChar, .modemIrq);

  remote_modem_model i_modem (.clk, .wantActive, .lag, .pins(modemPins));

  // ********************************************************************
  // Flow reference model
  // ********************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mHalt <= 1'b0; mPause <= 1'b0; mResume <= 1'b0; mRtsN <= 1'b1;
    end else begin
      mRtsN <= mHalt;
      mPause <= 1'b0;
      mResume <= 1'b0;
      if (swReset) begin
        mHalt <= 1'b0;
      end else if (!mHalt && mLev[3:0] != 0 && rxFifoCount >= 4 * mLev[3:0]) begin
        mHalt <= 1'b1;
        mPause <= autoSwFlowEn;
      end else if (mHalt && rxFifoCount <= 4 * mLev[7:4]) begin
        mHalt <= 1'b0;
        mResume <= autoSwFlowEn;
      end
    end
  end

  always @(negedge clk) begin
    if (flowChk) begin
      chk1("pauseSend", mPause, pauseSend);
      chk1("resumeSend", mResume, resumeSend);
      chk1("requestToSendN", mRtsN, requestToSendN);
    end
  end

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      badCount++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk8

  task automatic chk1(input string n, input logic e, input logic g);
    checksDone++;
    if (g !== e) begin
      badCount++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask : chk1

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic acc(input logic w, input logic r, input logic [7:0] d);
    tick();
    chk1("rdValidIdle", 1'b0, rdValid);
    regReq = '{`UMS_OFS_PAUSE, w, r, d};
    tick();
    regReq.wr = 1'b0;
    regReq.rd = 1'b0;
    if (r) begin
      chk1("rdValid", 1'b1, rdValid);
    end
  endtask : acc

  task automatic rdChk(input string n, input logic [7:0] e);
    acc(1'b0, 1'b1, 8'h00);
    chk8(n, e, rdData);
  endtask : rdChk

  task automatic pulseSw();
    tick();
    swReset = 1'b1;
    tick();
    swReset = 1'b0;
    mLev = 8'h00;
  endtask : pulseSw

  task automatic sweep();
    int step;
    while (rxFifoCount < 64) begin
      tick();
      step = $unsigned($random(seed)) % 6;
      rxFifoCount = (rxFifoCount + step > 64) ? 7'd64 : 7'(rxFifoCount + step);
    end
    repeat (3) tick();
    while (rxFifoCount > 0) begin
      tick();
      step = $unsigned($random(seed)) % 6;
      rxFifoCount = (rxFifoCount < step) ? 7'd0 : 7'(rxFifoCount - step);
    end
    repeat (3) tick();
  endtask : sweep

  task automatic endOfTest();
    $display("checks %0d bad %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : endOfTest

  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    endOfTest();
  end

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    logic [7:0] p, v, lev;
    logic [3:0] pv, oldP, mFlags;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    chk1("requestToSendN", 1'b1, requestToSendN);
    chk1("modemIrq", 1'b0, modemIrq);
    // Pause character bank
    lineFormatControl = `UMS_ENH_KEY;
    p = 8'($random(seed)) | 8'h01;
    acc(1'b1, 1'b0, p);
    rdChk("pauseChar", p);
    chk8("pauseCharPort", p, pauseChar);
    specialFeatureControl = 8'h04;
    rdChk("hiddenBank", 8'h00);
    acc(1'b1, 1'b0, ~p);
    specialFeatureControl = 8'h00;
    rdChk("pauseKept", p);
    pulseSw();
    rdChk("pauseAfterSw", p);
    // Modem inputs and change flags
    lineFormatControl = 8'h03;
    acc(1'b1, 1'b0, ~p);
    oldP = 4'hF;
    mFlags = 4'h0;
    rdChk("statusIdle", 8'h00);
    for (int i = 0; i < 14; i++) begin
      v = $random(seed);
      lag = v[5:4];
      modemIntEn = v[6];
      wantActive = v[3:0];
      pv = ~v[3:0];
      mFlags = mFlags | ((oldP ^ pv) & 4'b1011) | {1'b0, ~oldP[2] & pv[2], 2'b00};
      oldP = pv;
      repeat (10) tick();
      chk1("modemIrq", modemIntEn && mFlags != 0, modemIrq);
      if (v[7] || i == 13) begin
        rdChk("status", {~pv, mFlags});
        mFlags = 4'h0;
      end
    end
    rdChk("statusCleared", {~pv, 4'h0});
    // Internal loopback
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      modemOutputControl = {4'h1, v[3], 1'b0, v[1:0]};
      repeat (6) tick();
      acc(1'b0, 1'b1, 8'h00);
      chk8("loopStatus", {v[3], 1'b0, v[0], v[1], 4'h0}, rdData & 8'hF0);
    end
    // Flow thresholds
    modemOutputControl = 8'h04;
    enhancedFeatures = 8'h10;
    autoRtsEn = 1'b1;
    repeat (3) tick();
    flowChk = 1'b1;
    for (int r = 0; r < 3; r++) begin
      v = $random(seed);
      lev[3:0] = (r == 2) ? 4'h0 : 4'(1 + $unsigned($random(seed)) % 15);
      lev[7:4] = (r == 2) ? v[7:4] : 4'(v[7:4] % lev[3:0]);
      autoSwFlowEn = (r != 1);
      acc(1'b1, 1'b0, lev);
      mLev = lev;
      rdChk("levels", lev);
      sweep();
    end
    acc(1'b1, 1'b0, 8'h13);
    mLev = 8'h13;
    rxFifoCount = 7'd64;
    repeat (4) tick();
    pulseSw();
    repeat (4) tick();
    rdChk("levelsAfterSw", 8'h00);
    chk8("pauseAfterSw", p, pauseChar);
    flowChk = 1'b0;
    tick();
    rst = 1'b1;
    tick();
    rst = 1'b0;
    chk8("pauseAfterPor", 8'h00, pauseChar);
    endOfTest();
  end
endmodule : uart_modem_status_flow_thresholds_tb_top
